// *** ttlft_pkg.sv ***
// Purpose: Shared constants for the TTL input function trigger block
// Assumes: 40 MHz module clock, classic Wishbone register access
// Notes:   Target bit positions are shared by the register map and outputs
package ttlft_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned TRIG_ACCEPT_MS = 50; // Always recognised from here
  localparam int unsigned TRIG_REJECT_MS = 4; // Never recognised at or below
  localparam int unsigned TRIG_QUAL_MS = 10; // Chosen qualify point between both
  localparam int unsigned TRIG_QUAL_CYCLES = (TRIG_QUAL_MS * (CLK_HZ / 1000));
  localparam int unsigned TRIG_REJECT_CYCLES = (TRIG_REJECT_MS * (CLK_HZ / 1000));
  localparam int unsigned TRIG_CNT_W = 19;

  // ----------------------------------------------------------------
  // Control types: bit 1 selects pulse, bit 0 selects inverted
  // ----------------------------------------------------------------
  localparam logic [1:0] CTYPE_NORM_EDGE = 2'h0;
  localparam logic [1:0] CTYPE_INV_EDGE = 2'h1;
  localparam logic [1:0] CTYPE_NORM_PULSE = 2'h2;
  localparam logic [1:0] CTYPE_INV_PULSE = 2'h3;
  localparam int unsigned CTYPE_PULSE_BIT = 1;
  localparam int unsigned CTYPE_INV_BIT = 0;

  // ----------------------------------------------------------------
  // Target function bit positions
  // ----------------------------------------------------------------
  localparam int unsigned NUM_TARGETS = 23;
  localparam int unsigned TGT_INJ_LEFT = 0;
  localparam int unsigned TGT_INJ_RIGHT = 1;
  localparam int unsigned TGT_TRAY_HP_A = 2;
  localparam int unsigned TGT_TRAY_HP_B = 3;
  localparam int unsigned TGT_TRAY_LP_A = 4;
  localparam int unsigned TGT_TRAY_LP_B = 5;
  localparam int unsigned TGT_REAR_LP_A = 6; // A..F occupy 6..11
  localparam int unsigned TGT_DET_RUN_1 = 12;
  localparam int unsigned TGT_DET_RUN_2 = 13;
  localparam int unsigned TGT_AUTO_OFS_1 = 14;
  localparam int unsigned TGT_AUTO_OFS_2 = 15;
  localparam int unsigned TGT_MARK_1 = 16;
  localparam int unsigned TGT_MARK_2 = 17;
  localparam int unsigned TGT_SUPP_1 = 18;
  localparam int unsigned TGT_SUPP_2 = 19;
  localparam int unsigned TGT_HEATER = 20;
  localparam int unsigned TGT_AC_RELAY_1 = 21;
  localparam int unsigned TGT_AC_RELAY_2 = 22;
  // Single-action targets: auto-offset and mark
  localparam logic [22:0] TGT_SINGLE_MASK = 23'h03_C000;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int unsigned ADR_W = 8;
  localparam logic [7:0] REG_CFG_BASE = 8'h00; // One word per input
  localparam logic [7:0] REG_TGT_STATE = 8'h40;
  localparam logic [7:0] REG_IN_LEVEL = 8'h44;
  localparam int unsigned CFG_TYPE_LSB = 0;
  localparam int unsigned CFG_MASK_LSB = 8;
  localparam logic [1:0] CFG_TYPE_RST = CTYPE_NORM_EDGE;
  localparam logic [22:0] CFG_MASK_RST = 23'h00_0000;
  localparam int unsigned MAX_INPUTS = 16;

endpackage : ttlft_pkg

// *** ttlft_trigger.sv ***
// Purpose: Trigger logic behind a bank of TTL inputs driven by an
//          outside controlling device; edges set or clear, qualified pulses
//          only set the assigned target functions
// Assumes: One 40 MHz clock, synchronous active-high reset, classic
//          Wishbone slave for configuration and status
// Notes:   Target levels are held here; single-action targets only pulse
//
// What this block does
// [R01] Four control types: edges and pulses, both polarities
// [R02] Control type chosen separately per input
// [R03] Reset leaves every input in normal edge
// [R04] Each input drives its whole assigned target set
// [R05] Valves, detectors, suppressors, heater, relays are targets
// [R06] Assignments are one global table, not per host
// [R07] Normal edge: falling edge activates targets
// [R08] Normal edge: rising edge deactivates two-state targets
// [R09] Normal edge: rising edge ignores mark, auto-offset
// [R10] Injection valve: load on fall, inject on rise
// [R11] Detector run: start on fall, stop on rise
// [R12] Inverted edge swaps rising and falling roles
// [R13] Normal pulse: only falling side triggers
// [R14] Pulses of 50 ms or longer always trigger
// [R15] Pulses of 4 ms or shorter never trigger
// [R16] Inverted pulse uses rising side as active
// [R17] Controller holds active level at least 50 ms
// [R18] Inputs synchronised; width counted in clock cycles
`timescale 1ns/10ps
`default_nettype none

module ttlft_trigger
  import ttlft_pkg::*;
#(
  parameter int unsigned NUM_INPUTS = 8,
  parameter int unsigned QUAL_CYCLES = TRIG_QUAL_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  // TTL input pins
  input wire logic [NUM_INPUTS-1:0] ttl_in_i,
  // Target functions
  output logic [NUM_TARGETS-1:0] target_state_o,
  output logic [NUM_TARGETS-1:0] target_pulse_o
);

  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NUM_INPUTS-1:0] sync_a;
    logic [NUM_INPUTS-1:0] sync_b;
    logic [NUM_INPUTS-1:0] last;
    logic [NUM_INPUTS-1:0][TRIG_CNT_W-1:0] cnt;
    logic [NUM_INPUTS-1:0][1:0] ctype;
    logic [NUM_INPUTS-1:0][NUM_TARGETS-1:0] mask;
    logic [NUM_TARGETS-1:0] tgt;
    logic [NUM_TARGETS-1:0] shot;
    logic ack;
    logic [31:0] dat;
  } ttlft_state_s;

  ttlft_state_s s;
  ttlft_state_s next_s;

  localparam logic [TRIG_CNT_W-1:0] QUAL_CNT = TRIG_CNT_W'(QUAL_CYCLES);
  localparam logic [TRIG_CNT_W-1:0] QUAL_LAST = TRIG_CNT_W'(QUAL_CYCLES - 1);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Decode of a per-input configuration word
  function automatic logic cfg_hit(input logic [ADR_W-1:0] adr);
    cfg_hit = (adr[ADR_W-1:6] == REG_CFG_BASE[ADR_W-1:6]) &&
              (32'(adr[5:2]) < NUM_INPUTS) && (adr[1:0] == 2'h0);
  endfunction

  // Byte-lane merge of a write onto an old word
  function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    lane_merge = res;
  endfunction

  // Packing of one input's configuration word
  function automatic logic [31:0] cfg_word(input logic [1:0] ct,
                                           input logic [NUM_TARGETS-1:0] mk);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[CFG_TYPE_LSB +: 2] = ct;
    w[CFG_MASK_LSB +: NUM_TARGETS] = mk;
    cfg_word = w;
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [NUM_TARGETS-1:0] on_req;
    logic [NUM_TARGETS-1:0] off_req;
    logic lvl;
    logic rise;
    logic fall;
    logic inv;
    logic act_edge;
    logic deact_edge;
    logic act_lvl;
    logic [3:0] idx;
    logic [31:0] wr_word;
    on_req = '0;
    off_req = '0;
    lvl = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    inv = 1'b0;
    act_edge = 1'b0;
    deact_edge = 1'b0;
    act_lvl = 1'b0;
    idx = wb_adr_i[5:2];
    wr_word = 32'h0000_0000;
    next_s = s;

    // Pin synchronisers and edge history
    next_s.sync_a = ttl_in_i; // [R18]
    next_s.sync_b = s.sync_a; // [R18]
    next_s.last = s.sync_b;

    // Per-input trigger interpretation, each with its own type
    for (int i = 0; i < NUM_INPUTS; i++) begin
      lvl = s.sync_b[i];
      rise = lvl & ~s.last[i];
      fall = ~lvl & s.last[i];
      inv = s.ctype[i][CTYPE_INV_BIT]; // [R02] [R12] [R16]
      act_edge = inv ? rise : fall; // [R07] [R12]
      deact_edge = inv ? fall : rise; // [R08] [R12]
      act_lvl = inv ? lvl : ~lvl; // [R13] [R16]
      if (!s.ctype[i][CTYPE_PULSE_BIT]) begin
        // Edge types: active edge on, other edge off for two-state targets
        next_s.cnt[i] = '0;
        if (act_edge) begin
          on_req = on_req | s.mask[i]; // [R04] [R07] [R10] [R11]
        end
        if (deact_edge) begin
          off_req = off_req | (s.mask[i] & ~TGT_SINGLE_MASK); // [R08] [R09] [R10] [R11]
        end
      end else begin
        // Pulse types: count active level, fire once at qualify point
        if (act_lvl) begin
          if (s.cnt[i] != QUAL_CNT) begin
            next_s.cnt[i] = s.cnt[i] + 1'b1; // [R18]
          end
          if (s.cnt[i] == QUAL_LAST) begin
            on_req = on_req | s.mask[i]; // [R13] [R14] [R15] [R04]
          end
        end else begin
          next_s.cnt[i] = '0; // [R15] Short pulse discarded, inactive side ignored
        end
      end
    end

    // Global target table: activation wins over deactivation
    next_s.tgt = (s.tgt & ~off_req) | on_req; // [R06] [R05]
    next_s.tgt = next_s.tgt & ~TGT_SINGLE_MASK; // [R09]
    next_s.shot = on_req; // [R05]

    // Wishbone slave: answer one cycle after the request
    next_s.ack = 1'b0;
    if (wb_cyc_i && wb_stb_i && !s.ack) begin
      next_s.ack = 1'b1;
      next_s.dat = 32'h0000_0000;
      if (cfg_hit(wb_adr_i)) begin
        next_s.dat = cfg_word(s.ctype[idx], s.mask[idx]);
        if (wb_we_i) begin
          wr_word = lane_merge(cfg_word(s.ctype[idx], s.mask[idx]), wb_dat_i, wb_sel_i);
          next_s.ctype[idx] = wr_word[CFG_TYPE_LSB +: 2]; // [R01] [R02]
          next_s.mask[idx] = wr_word[CFG_MASK_LSB +: NUM_TARGETS]; // [R04] [R06]
          next_s.cnt[idx] = '0;
        end
      end else if (wb_adr_i == REG_TGT_STATE) begin
        next_s.dat[NUM_TARGETS-1:0] = s.tgt;
      end else if (wb_adr_i == REG_IN_LEVEL) begin
        next_s.dat[NUM_INPUTS-1:0] = s.sync_b;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0; // [R03] Normal edge, empty target sets
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state record
  assign wb_ack_o = s.ack;
  assign wb_dat_o = s.dat;
  assign target_state_o = s.tgt;
  assign target_pulse_o = s.shot;

endmodule : ttlft_trigger

`default_nettype wire

// *** ttlft_chk_properties.sv ***
// Purpose: Port assertions for ttlft_trigger
// Assumes: Sees only the top module ports
// Notes: Bound below the module
`timescale 1ns/10ps
`default_nettype none
module ttlft_chk
  import ttlft_pkg::*;
#(parameter int unsigned NUM_INPUTS = 8) (
  // Clock, reset and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  // Pins and targets
  input wire logic [NUM_INPUTS-1:0] ttl_in_i,
  input wire logic [NUM_TARGETS-1:0] target_state_o,
  input wire logic [NUM_TARGETS-1:0] target_pulse_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Bus steps
  sequence req_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence ack_s; wb_ack_o ##1 !wb_ack_o; endsequence
  sequence rd_s; wb_ack_o && !wb_we_i; endsequence
  bus_answer_a: assert property (req_s |=> ack_s) else $error("request not acked once");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  single_off_a: assert property (target_state_o[17:14] == 4'h0) else $error("single-action level set");
  rst_clear_a: assert property (disable iff (1'b0) rst_i |=> target_state_o == '0 && !wb_ack_o)
    else $error("reset left outputs set");
  act_pulse_a: assert property ((target_state_o & ~$past(target_state_o) & ~target_pulse_o) == '0)
    else $error("activation without pulse");
  fall_cause_a: assert property (|($past(target_state_o) & ~target_state_o) |->
    $past(ttl_in_i) != $past(ttl_in_i, 6)) else $error("deactivation without pin edge");
  unmap_zero_a: assert property (rd_s ##0 wb_adr_i >= 8'h48 |-> wb_dat_o == '0) else $error("unmapped read not 0");
  cfg_rsvd_a: assert property (rd_s ##0 wb_adr_i < 8'(4 * NUM_INPUTS) |-> wb_dat_o[7:2] == 6'h0 && !wb_dat_o[31])
    else $error("reserved config bits set");
endmodule // ttlft_chk
bind ttlft_trigger ttlft_chk #(.NUM_INPUTS(NUM_INPUTS)) i_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
  .ttl_in_i(ttl_in_i), .target_state_o(target_state_o), .target_pulse_o(target_pulse_o));
`default_nettype wire

// *** ttlft_ctrl_model.sv ***
// Purpose: Outside controlling device driving the TTL pins
// Assumes: Pins change just after a clock edge
// Notes: Idle level per pin set by IDLE
`timescale 1ns/10ps
`default_nettype none
module ttlft_ctrl_model #(parameter int unsigned N = 8, parameter logic [7:0] IDLE = 8'hf5) (
  // Clock and pins
  input wire logic clk_i,
  output logic [N-1:0] ttl_o
);
  initial ttl_o = IDLE;
  // Move one pin to a new level
  task automatic set(input int p, input logic v);
    @(posedge clk_i);
    ttl_o[p] <= v;
  endtask
  // Hold a level for c cycles, then return
  task automatic hold(input int p, input logic v, input int c);
    set(p, v);
    repeat (c) @(posedge clk_i);
    ttl_o[p] <= ~v;
  endtask
endmodule // ttlft_ctrl_model
`default_nettype wire

// *** test_ttl_input_function_trigger.sv ***
// Purpose: Self-checking bench for ttlft_trigger
// Assumes: Short qualify count QC in simulation
// Notes: Reads are noted in a queue and checked on ack
`timescale 1ns/10ps
`default_nettype none
module test_ttl_input_function_trigger;
  import ttlft_pkg::*;
  localparam int QC = 20;
  localparam int ACC = QC * TRIG_ACCEPT_MS / TRIG_QUAL_MS;
  localparam int REJ = QC * TRIG_REJECT_MS / TRIG_QUAL_MS;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack;
  logic [7:0] adr = '0, ttl;
  logic [3:0] sel = '0;
  logic [31:0] dat = '0, rdat;
  logic [22:0] st, pl, rnd;
  logic [31:0] q[$];
  int fail_count = 0, check_count = 0, cycles = 0, seed = 87;
  ttlft_trigger #(.NUM_INPUTS(8), .QUAL_CYCLES(QC)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_ack_o(ack),
    .wb_dat_o(rdat), .ttl_in_i(ttl), .target_state_o(st), .target_pulse_o(pl));
  ttlft_ctrl_model #(.N(8), .IDLE(8'hf5)) i_ctrl (.clk_i(clk_i), .ttl_o(ttl));
  // Clock
  initial forever #12.5 clk_i = ~clk_i;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // One classic Wishbone cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk_i);
    end
    if (ack !== 1'b1) fail_count++;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  // Write config with random reserved bits, read it back
  task automatic cfg(input int i, input logic [1:0] t, input logic [22:0] m);
    bus(1'b1, 8'(4 * i), {1'($random(seed)), m, 6'($random(seed)), t});
    rd(8'(4 * i), {1'b0, m, 6'h0, t});
  endtask
  // Move a pin, collect target pulses, check levels on the port and the bus
  task automatic pin(input int p, input logic v, input logic [22:0] e, input logic [22:0] pe);
    logic [22:0] acc;
    acc = '0;
    i_ctrl.set(p, v);
    repeat (6) begin
      @(posedge clk_i);
      acc = acc | pl;
    end
    check(32'(st), 32'(e));
    check(32'(acc), 32'(pe));
    rd(REG_TGT_STATE, {9'h0, e});
  endtask
  // Read monitor and timeout
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 20000) begin
      fail_count++;
      end_sim();
    end
    if (ack === 1'b1 && we === 1'b0) check(rdat, q.size() > 0 ? q.pop_front() : 32'hdead_beef);
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 8; i++) rd(8'(4 * i), 32'h0);
    rd(8'h48, 32'h0);
    cfg(0, CTYPE_NORM_EDGE, 23'h01_1001);
    cfg(1, CTYPE_INV_EDGE, 23'h10_0000);
    cfg(2, CTYPE_NORM_PULSE, 23'h20_0000);
    cfg(3, CTYPE_INV_PULSE, 23'h40_4000);
    rnd = 23'($random(seed));
    cfg(5, CTYPE_NORM_EDGE, rnd);
    pin(0, 1'b0, 23'h00_1001, 23'h01_1001);
    pin(0, 1'b1, 23'h00_0000, 23'h00_0000);
    pin(1, 1'b1, 23'h10_0000, 23'h10_0000);
    pin(1, 1'b0, 23'h00_0000, 23'h00_0000);
    i_ctrl.hold(2, 1'b0, REJ);
    pin(4, 1'b1, 23'h00_0000, 23'h00_0000);
    i_ctrl.hold(2, 1'b0, ACC);
    pin(4, 1'b1, 23'h20_0000, 23'h00_0000);
    i_ctrl.hold(3, 1'b1, ACC);
    pin(4, 1'b1, 23'h60_0000, 23'h00_0000);
    pin(5, 1'b0, 23'h60_0000 | (rnd & ~TGT_SINGLE_MASK), rnd);
    repeat (4) @(posedge clk_i);
    check(32'(q.size()), 32'h0);
    end_sim();
  end
endmodule // test_ttl_input_function_trigger
`default_nettype wire
